// *** rtl/nos_pkg.sv ***
// Constants, register map and bus carrier types of the sixteen-channel output strobe port.
// Assumes a 100 MHz ref_clk and a VME A16/D16 bus whose pins arrive unsynchronised.
package nos_pkg;

   // ------------------------------------------------------------
   // Register map (byte offsets inside the 64-byte block)
   // ------------------------------------------------------------
   localparam logic [5:0]  OUTPUT_PATTERN_OFS   = 6'h00;
   localparam logic [5:0]  STROBE_SELECT_OFS    = 6'h02;
   localparam logic [5:0]  PULSE_WIDTH_OFS      = 6'h04;
   localparam logic [5:0]  TRANSFER_CONTROL_OFS = 6'h06;
   localparam int          CTRL_GO_BIT          = 0;
   localparam int          CTRL_TIMEBASE_BIT    = 1;
   localparam logic [15:0] REG_RESET            = 16'h0000;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   localparam logic [5:0]  AM_A16_USER          = 6'h29;
   localparam logic [5:0]  AM_A16_SUPER         = 6'h2D;

   // ------------------------------------------------------------
   // Timebase: phase accumulator in units of 100 ps
   // ------------------------------------------------------------
   localparam int          CLK_PERIOD_PS        = 10000;
   localparam int          FINE_STEP_PS         = 62500;
   localparam logic [9:0]  ACC_STEP             = 10'(CLK_PERIOD_PS / 100);
   localparam logic [9:0]  ACC_WRAP             = 10'(FINE_STEP_PS / 100);
   localparam logic [15:0] COARSE_LAST          = 16'hFFFF;

   typedef struct packed {
      logic        asN;
      logic [1:0]  dsN;
      logic        writeN;
      logic        lwordN;
      logic [5:0]  am;
      logic [15:1] addr;
      logic [15:0] data;
   } nos_vme_in_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } nos_bus_state_t;

endpackage : nos_pkg

// *** rtl/nos_port.sv ***
// Sixteen-output level/strobe port with its VME A16/D16 slave.
// Assumes the VME bus pins and the base switches are asynchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module nos_port (
   input  wire logic               ref_clk,
   input  wire logic               sys_rst,
   input  wire nos_pkg::nos_vme_in_t vmeIn,
   input  wire logic [15:6]        baseSwitch,
   output logic      [15:0]        vmeDataOut,
   output logic                    vmeDataOeN,
   output logic                    dtackOut,
   output logic                    dtackOeN,
   output logic      [15:0]        nimOut
);
   import nos_pkg::*;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   nos_vme_in_t    vmeS1, vmeS2;
   logic [15:6]    baseS1, baseS2;
   logic           dsLowPrev;
   nos_bus_state_t state;
   logic [15:0]    outputPattern, strobeSelect, pulseWidth, transferControl;
   logic [15:0]    strobeMask;
   logic           busy;
   logic [16:0]    remain;
   logic [9:0]     acc;
   logic           fineTick;
   logic [15:0]    coarseCnt;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         vmeS1     <= '1;
         vmeS2     <= '1;
         baseS1    <= '0;
         baseS2    <= '0;
         dsLowPrev <= 1'b0;
      end else begin
         vmeS1     <= vmeIn;
         vmeS2     <= vmeS1;
         baseS1    <= baseSwitch;
         baseS2    <= baseS1;
         dsLowPrev <= (vmeS2.dsN == 2'b00);
      end
   end

   function automatic logic amOk(input logic [5:0] am);
      amOk = (am == AM_A16_USER) || (am == AM_A16_SUPER);
   endfunction : amOk

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   // Data strobes must be seen low twice so the synchronised address and data have settled.
   logic       cycleSeen, hit, doWrite, doRead, fire;
   logic [5:0] ofs;
   logic [15:0] readValue;
   assign cycleSeen = !vmeS2.asN && (vmeS2.dsN == 2'b00) && dsLowPrev;
   assign hit       = cycleSeen && (vmeS2.addr[15:6] == baseS2) && amOk(vmeS2.am)
                      && vmeS2.lwordN;
   assign ofs       = {vmeS2.addr[5:1], 1'b0};
   assign doWrite   = (state == BUS_IDLE) && hit && !vmeS2.writeN;
   assign doRead    = (state == BUS_IDLE) && hit && vmeS2.writeN;
   assign fire      = doWrite && (ofs == TRANSFER_CONTROL_OFS) && vmeS2.data[CTRL_GO_BIT];

   always_comb begin
      case (ofs)
         OUTPUT_PATTERN_OFS:   readValue = outputPattern;
         STROBE_SELECT_OFS:    readValue = strobeSelect;
         PULSE_WIDTH_OFS:      readValue = pulseWidth;
         TRANSFER_CONTROL_OFS: readValue = {transferControl[15:1], busy};
         default:              readValue = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state      <= BUS_IDLE;
         dtackOut   <= 1'b0;
         dtackOeN   <= 1'b1;
         vmeDataOut <= 16'h0000;
         vmeDataOeN <= 1'b1;
      end else begin
         dtackOut <= 1'b0;
         case (state)
            BUS_IDLE: begin
               if (hit) begin
                  state      <= BUS_ACK;
                  dtackOeN   <= 1'b0;
                  vmeDataOut <= readValue;
                  vmeDataOeN <= !doRead;
               end
            end
            BUS_ACK: begin
               if (vmeS2.dsN != 2'b00) begin
                  state      <= BUS_IDLE;
                  dtackOeN   <= 1'b1;
                  vmeDataOeN <= 1'b1;
               end
            end
            default: begin
               state      <= BUS_IDLE;
               dtackOeN   <= 1'b1;
               vmeDataOeN <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         outputPattern   <= REG_RESET;
         strobeSelect    <= REG_RESET;
         pulseWidth      <= REG_RESET;
         transferControl <= REG_RESET;
      end else if (doWrite) begin
         case (ofs)
            OUTPUT_PATTERN_OFS:   outputPattern   <= vmeS2.data;
            STROBE_SELECT_OFS:    strobeSelect    <= vmeS2.data;
            PULSE_WIDTH_OFS:      pulseWidth      <= vmeS2.data;
            TRANSFER_CONTROL_OFS: transferControl <= vmeS2.data;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Strobe timebase
   // ------------------------------------------------------------
   // 62.5 ns is not a whole number of clocks, so ticks fall every 6 or 7 clocks and average exactly.
   logic [9:0] accSum;
   logic       coarseTick, tick;
   assign accSum     = acc + ACC_STEP;
   assign coarseTick = fineTick && (coarseCnt == COARSE_LAST);
   assign tick       = transferControl[CTRL_TIMEBASE_BIT] ? coarseTick : fineTick;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc      <= 10'h000;
         fineTick <= 1'b0;
      end else if (fire) begin
         acc      <= 10'h000;
         fineTick <= 1'b0;
      end else if (accSum >= ACC_WRAP) begin
         acc      <= accSum - ACC_WRAP;
         fineTick <= 1'b1;
      end else begin
         acc      <= accSum;
         fineTick <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         coarseCnt <= 16'h0000;
      end else if (fire) begin
         coarseCnt <= 16'h0000;
      end else if (fineTick) begin
         coarseCnt <= coarseCnt + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Outputs and strobe timing
   // ------------------------------------------------------------
   // A zero width stands for full scale; a second transfer while busy restarts every strobe.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nimOut     <= 16'h0000;
         strobeMask <= 16'h0000;
         busy       <= 1'b0;
         remain     <= 17'h00000;
      end else if (fire) begin
         nimOut     <= outputPattern;
         strobeMask <= outputPattern & strobeSelect;
         busy       <= |(outputPattern & strobeSelect);
         remain     <= {pulseWidth == 16'h0000, pulseWidth};
      end else if (busy && tick) begin
         if (remain == 17'h00001) begin
            nimOut <= nimOut & ~strobeMask;
            busy   <= 1'b0;
         end else begin
            remain <= remain - 17'h00001;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_fire;
      fire;
   endsequence
   sequence s_strobe_end;
      busy && tick && (remain == 17'h00001) && !fire;
   endsequence
   // A transfer restarts the tick phase, so a late tick is only checked across a quiet stretch.
   sequence s_tick_quiet;
      fineTick && !fire ##1 !fire [*6];
   endsequence

   a_pattern_copy: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_fire |=> (nimOut == $past(outputPattern))) else $error("pattern not copied");
   a_level_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!fire && !busy) |=> $stable(nimOut)) else $error("level output moved");
   a_busy_on_strobe: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_fire |=> (busy == |($past(outputPattern) & $past(strobeSelect)))) else $error("busy wrong");
   a_strobe_end_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_strobe_end |=> !busy && ((nimOut & strobeMask) == 16'h0000)) else $error("strobe did not end");
   a_fine_tick_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
      fineTick |=> !fineTick [*5]) else $error("fine tick too close");
   a_fine_tick_due: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_tick_quiet |-> ##[0:1] fineTick) else $error("fine tick late");
   a_coarse_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
      fineTick && !fire |=> (coarseCnt == $past(coarseCnt) + 16'h0001)) else $error("coarse count off");
   a_status_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
      doRead && (ofs == TRANSFER_CONTROL_OFS) |=> (vmeDataOut[0] == $past(busy))) else $error("status bit wrong");
   a_read_back: assert property (@(posedge ref_clk) disable iff (sys_rst)
      doRead && (ofs == PULSE_WIDTH_OFS) |=> !vmeDataOeN && (vmeDataOut == $past(pulseWidth))) else $error("read back wrong");
   a_dtack_decode: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(dtackOeN) |-> $past(hit) && $past(vmeS2.lwordN)) else $error("answered foreign cycle");
   a_reset_clear: assert property (@(posedge ref_clk)
      $fell(sys_rst) |-> (nimOut == 16'h0000) && !busy) else $error("reset state wrong");

endmodule : nos_port
`default_nettype wire

// *** test/nos_vme_master.sv ***
// VME A16/D16 bus master model that drives the slave side of the output port.
// Assumes ref_clk is its clock and that the bench starts cycles through its access task.
`timescale 1ns/100ps
`default_nettype none
module nos_vme_master (
   input  wire logic                  ref_clk,
   output var  nos_pkg::nos_vme_in_t  vmeIn,
   input  wire logic [15:0]           vmeDataOut,
   input  wire logic                  vmeDataOeN,
   input  wire logic                  dtackOut,
   input  wire logic                  dtackOeN
);
   import nos_pkg::*;
   initial begin
      vmeIn = '{asN: 1'b1, dsN: 2'b11, writeN: 1'b1, lwordN: 1'b1, am: AM_A16_USER, addr: '0, data: 16'h5A5A};
   end
   // ------------------------------------------------------------
   // One bus cycle
   // ------------------------------------------------------------
   // A refused cycle gets no acknowledge, so the wait is bounded as a bus timer would be.
   task automatic access(input logic wr, input logic [5:0] ofs, input logic [15:0] wd, input logic lw,
                         input logic [15:6] base, output logic [15:0] rd, output logic ack);
      int n;
      ack = 1'b0;
      rd  = 16'h0000;
      @(posedge ref_clk) #1;
      vmeIn.writeN = ~wr;
      vmeIn.lwordN = lw;
      vmeIn.addr   = {base, ofs[5:1]};
      vmeIn.data   = wr ? wd : ~vmeIn.data;
      vmeIn.asN    = 1'b0;
      vmeIn.dsN    = 2'b00;
      for (n = 0; n < 30 && !ack; n++) begin
         @(posedge ref_clk);
         if (dtackOeN === 1'b0 && dtackOut === 1'b0) begin
            ack = 1'b1;
            // Undriven data lines float up to the terminator level.
            rd  = (vmeDataOeN === 1'b0) ? vmeDataOut : 16'hFFFF;
         end
      end
      #1;
      vmeIn.asN  = 1'b1;
      vmeIn.dsN  = 2'b11;
      vmeIn.data = ~vmeIn.data;
      for (n = 0; n < 10 && dtackOeN !== 1'b1; n++) begin
         @(posedge ref_clk);
      end
   endtask : access
   task automatic setAm(input logic [5:0] m);
      @(posedge ref_clk) #1;
      vmeIn.am = m;
   endtask : setAm
endmodule : nos_vme_master
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench of the output strobe port with a VME master model.
// Assumes nos_pkg, nos_port and nos_vme_master are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import nos_pkg::*;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   nos_vme_in_t vmeIn;
   logic [15:6] baseSwitch;
   logic [15:0] vmeDataOut, nimOut, r, p, s;
   logic        vmeDataOeN, dtackOut, dtackOeN, a;
   int          badCount, checks, cycles, i, n;
   int          seed = 32'h4FBD5CF6;
   nos_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .vmeIn(vmeIn), .baseSwitch(baseSwitch),
                 .vmeDataOut(vmeDataOut), .vmeDataOeN(vmeDataOeN), .dtackOut(dtackOut),
                 .dtackOeN(dtackOeN), .nimOut(nimOut));
   nos_vme_master master (.ref_clk(ref_clk), .vmeIn(vmeIn), .vmeDataOut(vmeDataOut), .vmeDataOeN(vmeDataOeN),
                          .dtackOut(dtackOut), .dtackOeN(dtackOeN));
   always #5 ref_clk = ~ref_clk;
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic stopTest();
      $display("checks=%0d bad=%0d", checks, badCount);
      if (badCount == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stopTest
   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check16
   function automatic logic [15:0] expOut(input logic [15:0] pat, sel, input logic ended);
      return ended ? (pat & ~sel) : pat;
   endfunction : expOut
   task automatic wr(input logic [5:0] ofs, input logic [15:0] v);
      master.access(1'b1, ofs, v, 1'b1, baseSwitch, r, a);
      check16({15'h0000, a}, 16'h0001);
   endtask : wr
   task automatic rd(input logic [5:0] ofs);
      master.access(1'b0, ofs, 16'h0000, 1'b1, baseSwitch, r, a);
      check16({15'h0000, a}, 16'h0001);
   endtask : rd
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         stopTest();
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      baseSwitch = 10'($random(seed));
      repeat (10) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      check16(nimOut, 16'h0000);
      rd(6'h06); check16(r, 16'h0000);
      for (i = 0; i < 3; i++) begin
         p = 16'($random(seed)); wr(6'(2 * i), p); rd(6'(2 * i)); check16(r, p);
      end
      p = 16'($random(seed)) & 16'hFFFC; wr(6'h06, p); rd(6'h06); check16(r, p);
      check16(nimOut, 16'h0000);
      wr(6'h3E, 16'hFFFF); rd(6'h3E); check16(r, 16'h0000);
      master.access(1'b0, 6'h00, 16'h0000, 1'b1, baseSwitch ^ 10'h001, r, a);
      check16({15'h0000, a}, 16'h0000);
      master.access(1'b1, 6'h00, 16'hFFFF, 1'b0, baseSwitch, r, a);
      check16({15'h0000, a}, 16'h0000);
      master.setAm(AM_A16_SUPER);
      p = 16'($random(seed)); wr(6'h02, p); rd(6'h02); check16(r, p);
      master.setAm(6'h39);
      master.access(1'b0, 6'h02, 16'h0000, 1'b1, baseSwitch, r, a);
      check16({15'h0000, a}, 16'h0000);
      master.setAm(AM_A16_USER);
      p = 16'($random(seed)); wr(6'h00, p); wr(6'h02, 16'h0000); wr(6'h06, 16'h0001);
      check16(nimOut, p);
      rd(6'h06); check16({15'h0000, r[0]}, 16'h0000);
      // Strobe width 16 at the fine step is 1000 ns, i.e. 100 clocks from the take.
      for (i = 0; i < 3; i++) begin
         p = 16'($random(seed)) | 16'h0001; s = 16'($random(seed)) | 16'h0001;
         wr(6'h00, p); wr(6'h02, s); wr(6'h04, 16'h0010); wr(6'h06, 16'h0001);
         n = 0;
         check16(nimOut, expOut(p, s, 1'b0));
         while (nimOut === p && n < 200) begin
            @(posedge ref_clk); n++;
         end
         check16({15'h0000, n > 75 && n < 100}, 16'h0001);
         check16(nimOut, expOut(p, s, 1'b1));
         rd(6'h06); check16({15'h0000, r[0]}, 16'h0000);
      end
      wr(6'h04, 16'h0001); wr(6'h06, 16'h0003);
      repeat (3000) @(posedge ref_clk);
      check16(nimOut, p);
      rd(6'h06); check16({15'h0000, r[0]}, 16'h0001);
      wr(6'h06, 16'h0001);
      repeat (30) @(posedge ref_clk);
      check16(nimOut, expOut(p, s, 1'b1));
      stopTest();
   end
endmodule : tb_top
`default_nettype wire
